// ===== rtl/wkld_pkg.sv
// Package: register map, field positions and reset values of the wake and port-off block
package wkld_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] WKLD_OFS_WAKEUP_CONTROL = 8'h00;
    localparam logic [7:0] WKLD_OFS_PM_CTRL_STATUS = 8'h04;
    localparam logic [7:0] WKLD_OFS_BLOCK_STATUS   = 8'h08;
    localparam logic [7:0] WKLD_OFS_IRQ_STATUS     = 8'h0c;
    localparam logic [7:0] WKLD_OFS_IRQ_ENABLE     = 8'h10;
    localparam logic [7:0] WKLD_OFS_IRQ_CLEAR      = 8'h14;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int WKLD_BIT_ADV_PM_ENABLE  = 0;
    localparam int WKLD_BIT_WAKE_ENABLE    = 0;
    localparam int WKLD_BIT_WAKE_STATUS    = 1;
    localparam int WKLD_BIT_AUX_PRESENT    = 0;
    localparam int WKLD_BIT_D3COLD_WAKE    = 1;
    localparam int WKLD_BIT_PORT_DISABLED  = 2;
    localparam int WKLD_BIT_LOW_POWER      = 3;
    localparam int WKLD_BIT_FLASH_IN_USE   = 4;
    localparam int WKLD_BIT_WAKE_DRIVEN    = 5;
    localparam int WKLD_IRQ_WIDTH          = 3;
    localparam int WKLD_IRQ_WAKE_EVENT     = 0;
    localparam int WKLD_IRQ_WAKE_ASSERT    = 1;
    localparam int WKLD_IRQ_AUX_CHANGE     = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic                      WKLD_RST_ENABLE = 1'b0;
    localparam logic [WKLD_IRQ_WIDTH-1:0] WKLD_RST_IRQ    = 3'h0;
    localparam logic [31:0]               WKLD_RDATA_ZERO = 32'h0000_0000;

    // ----------------------------------------
    // AHB-Lite encodings
    // ----------------------------------------
    localparam logic [1:0] WKLD_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] WKLD_HTRANS_SEQ    = 2'h3;

endpackage : wkld_pkg

// ===== rtl/wkld_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none

module wkld_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ----------------------------------------
    // One two-stage chain per bit
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi] <= async_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;

endmodule : wkld_sync

`default_nettype wire

// ===== rtl/wkld_top.sv
// Wake request and port-off logic with AHB-Lite register access
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module wkld_top (
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // PCI reset pin
    input  wire logic        pci_rst_n,
    // Wake sources and power indication
    input  wire logic        wake_event,
    input  wire logic        aux_power_present,
    input  wire logic        flash_in_use,
    // Shared flash data bit 0 / port-off pin
    input  wire logic        flash_data_bus_0_in,
    output logic             flash_data_bus_0_out,
    output logic             flash_data_bus_0_oe,
    output logic             flash_data_0,
    // Wake request open-drain pin
    output logic             wake_request_n_out,
    output logic             wake_request_n_oe,
    // Port state
    output logic             port_disabled,
    output logic             low_power,
    output logic             d3cold_wake_adv,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt
    output logic             irq
);

    localparam int IW = wkld_pkg::WKLD_IRQ_WIDTH;

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [3:0] pins_s;
    logic       pci_rst_s;
    logic       aux_s;
    logic       port_pin_s;
    logic       wake_ev_s;

    wkld_sync #(.WIDTH(4)) wkld_sync_inst (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({wake_event, flash_data_bus_0_in, aux_power_present, pci_rst_n}),
        .sync_out (pins_s)
    );

    assign pci_rst_s  = pins_s[0];
    assign aux_s      = pins_s[1];
    assign port_pin_s = pins_s[2];
    assign wake_ev_s  = pins_s[3];

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic          pci_rst_q,  pci_rst_d;
    logic          adv_power_mgmt_enable_q,     adv_power_mgmt_enable_d;
    logic          wen_q,      wen_d;
    logic          wst_q,      wst_d;
    logic          pdis_q,     pdis_d;
    logic          aux_q,      aux_d;
    logic          wev_q,      wev_d;
    logic [IW-1:0] ist_q,      ist_d;
    logic [IW-1:0] ien_q,      ien_d;
    logic          fl0_q,      fl0_d;
    logic          wr_q,       wr_d;
    logic          rd_q,       rd_d;
    logic [7:0]    addr_q,     addr_d;
    logic [31:0]   rdata_q,    rdata_d;

    logic pci_rise;
    logic in_pci_rst;
    logic wake_rise;
    logic wake_drive;
    logic addr_ph;
    logic [IW-1:0] ev;

    assign pci_rise   = pci_rst_s && !pci_rst_q;
    assign in_pci_rst = !pci_rst_s;
    assign wake_rise  = wake_ev_s && !wev_q;
    assign wake_drive = wst_q && (wen_q || adv_power_mgmt_enable_q);
    assign addr_ph    = hsel && hready && (htrans == wkld_pkg::WKLD_HTRANS_NONSEQ ||
                                           htrans == wkld_pkg::WKLD_HTRANS_SEQ);
    assign ev         = {aux_s != aux_q, wake_rise && (wen_q || adv_power_mgmt_enable_q) && !in_pci_rst,
                         wake_rise && !in_pci_rst};

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        pci_rst_d = pci_rst_s;
        aux_d     = aux_s;
        wev_d     = wake_ev_s;
        adv_power_mgmt_enable_d    = adv_power_mgmt_enable_q;
        wen_d     = wen_q;
        wst_d     = wst_q;
        pdis_d    = pdis_q;
        ien_d     = ien_q;
        fl0_d     = flash_in_use ? port_pin_s : fl0_q;
        wr_d      = addr_ph && hwrite;
        rd_d      = addr_ph && !hwrite;
        addr_d    = addr_ph ? haddr : addr_q;
        rdata_d   = rdata_q;
        ist_d     = ist_q;
        // Bus writes, ignored while PCI reset holds
        if (wr_q && !in_pci_rst)
        begin
            case (addr_q)
                wkld_pkg::WKLD_OFS_WAKEUP_CONTROL: adv_power_mgmt_enable_d = hwdata[wkld_pkg::WKLD_BIT_ADV_PM_ENABLE];
                wkld_pkg::WKLD_OFS_PM_CTRL_STATUS:
                begin
                    wen_d = hwdata[wkld_pkg::WKLD_BIT_WAKE_ENABLE];
                    if (hwdata[wkld_pkg::WKLD_BIT_WAKE_STATUS])
                        wst_d = 1'b0;
                end
                wkld_pkg::WKLD_OFS_IRQ_ENABLE: ien_d = hwdata[IW-1:0];
                wkld_pkg::WKLD_OFS_IRQ_CLEAR:  ist_d = ist_q & ~hwdata[IW-1:0];
                default: ;
            endcase
        end
        // Wake event sets status; set wins over clear
        if (wake_rise)
            wst_d = 1'b1;
        // Reset release: advanced PM enable always cleared; wake enable kept only with aux power
        if (pci_rise)
        begin
            adv_power_mgmt_enable_d = wkld_pkg::WKLD_RST_ENABLE;
            pdis_d = !port_pin_s && !flash_in_use;
            if (!aux_s)
            begin
                wen_d = wkld_pkg::WKLD_RST_ENABLE;
                wst_d = wake_rise;
            end
        end
        ist_d = ist_d | ev;
        // Read data
        rdata_d = wkld_pkg::WKLD_RDATA_ZERO;
        if (rd_q || (addr_ph && !hwrite))
        begin
            case (addr_ph ? haddr : addr_q)
                wkld_pkg::WKLD_OFS_WAKEUP_CONTROL: rdata_d[wkld_pkg::WKLD_BIT_ADV_PM_ENABLE] = adv_power_mgmt_enable_q;
                wkld_pkg::WKLD_OFS_PM_CTRL_STATUS:
                begin
                    rdata_d[wkld_pkg::WKLD_BIT_WAKE_ENABLE] = wen_q;
                    rdata_d[wkld_pkg::WKLD_BIT_WAKE_STATUS] = wst_q;
                end
                wkld_pkg::WKLD_OFS_BLOCK_STATUS:
                begin
                    rdata_d[wkld_pkg::WKLD_BIT_AUX_PRESENT]   = aux_s;
                    rdata_d[wkld_pkg::WKLD_BIT_D3COLD_WAKE]   = aux_s;
                    rdata_d[wkld_pkg::WKLD_BIT_PORT_DISABLED] = pdis_q;
                    rdata_d[wkld_pkg::WKLD_BIT_LOW_POWER]     = pdis_q;
                    rdata_d[wkld_pkg::WKLD_BIT_FLASH_IN_USE]  = flash_in_use;
                    rdata_d[wkld_pkg::WKLD_BIT_WAKE_DRIVEN]   = wake_drive;
                end
                wkld_pkg::WKLD_OFS_IRQ_STATUS: rdata_d[IW-1:0] = ist_q;
                wkld_pkg::WKLD_OFS_IRQ_ENABLE: rdata_d[IW-1:0] = ien_q;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_rst_q <= 1'b0;
            aux_q     <= 1'b0;
            wev_q     <= 1'b0;
            adv_power_mgmt_enable_q    <= wkld_pkg::WKLD_RST_ENABLE;
            wen_q     <= wkld_pkg::WKLD_RST_ENABLE;
            wst_q     <= 1'b0;
            pdis_q    <= 1'b0;
            ist_q     <= wkld_pkg::WKLD_RST_IRQ;
            ien_q     <= wkld_pkg::WKLD_RST_IRQ;
            fl0_q     <= 1'b0;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            addr_q    <= 8'h00;
            rdata_q   <= wkld_pkg::WKLD_RDATA_ZERO;
        end
        else
        begin
            pci_rst_q <= pci_rst_d;
            aux_q     <= aux_d;
            wev_q     <= wev_d;
            adv_power_mgmt_enable_q    <= adv_power_mgmt_enable_d;
            wen_q     <= wen_d;
            wst_q     <= wst_d;
            pdis_q    <= pdis_d;
            ist_q     <= ist_d;
            ien_q     <= ien_d;
            fl0_q     <= fl0_d;
            wr_q      <= wr_d;
            rd_q      <= rd_d;
            addr_q    <= addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wake_request_n_out   = 1'b0;
    assign wake_request_n_oe    = wake_drive;
    assign flash_data_bus_0_out = 1'b0;
    assign flash_data_bus_0_oe  = 1'b0;
    assign flash_data_0         = fl0_q;
    assign port_disabled        = pdis_q;
    assign low_power            = pdis_q;
    assign d3cold_wake_adv      = aux_s;
    assign hrdata               = rdata_q;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign irq                  = |(ist_q & ien_q);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_wake_pull_low: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_rise && (wen_q || adv_power_mgmt_enable_q) && !pci_rise) |=> wake_request_n_oe)
        else $error("wake request not driven after enabled event");
    chk_wake_release: assert property (@(posedge clk) disable iff (!rst_n)
        (!wst_q || (!wen_q && !adv_power_mgmt_enable_q)) |-> !wake_request_n_oe)
        else $error("wake request driven without status or enable");
    chk_aux_keeps_en: assert property (@(posedge clk) disable iff (!rst_n)
        (pci_rise && aux_s && wen_q && !wr_q) |=> wen_q)
        else $error("wake enable lost over reset with aux power");
    chk_noaux_clr_en: assert property (@(posedge clk) disable iff (!rst_n)
        (pci_rise && !aux_s) |=> !wen_q && !adv_power_mgmt_enable_q)
        else $error("enables not reset without aux power");
    chk_adv_follows: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(aux_s) |-> d3cold_wake_adv == aux_s)
        else $error("D3cold advertisement lags aux power");
    chk_port_sample: assert property (@(posedge clk) disable iff (!rst_n)
        (pci_rise && !port_pin_s && !flash_in_use) |=> port_disabled ##1 low_power)
        else $error("port not disabled after low sample");
    chk_port_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !pci_rise |=> $stable(port_disabled))
        else $error("port state changed outside reset edge");
    chk_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_q && in_pci_rst && !pci_rise) |=> $stable(adv_power_mgmt_enable_q))
        else $error("register written during PCI reset");
    chk_flash_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        !flash_data_bus_0_oe)
        else $error("shared pin driven");

    cov_wake_drive: cover property (@(posedge clk) disable iff (!rst_n) $rose(wake_request_n_oe));
    cov_port_off:   cover property (@(posedge clk) disable iff (!rst_n) $rose(port_disabled));
    cov_aux_keep:   cover property (@(posedge clk) disable iff (!rst_n) pci_rise && aux_s && wen_q);
    cov_irq:        cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule : wkld_top

`default_nettype wire

// ===== tb/wkld_host_model.sv
// Host side model: PCI reset, port-off line with pull-up, wake request pull-up
`timescale 1ns/100ps
`default_nettype none

module wkld_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench commands
    input  wire logic pci_req,
    input  wire logic gpio_off_req,
    input  wire logic flash_on,
    input  wire logic flash_bit,
    // Device pins
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic wake_out,
    input  wire logic wake_oe,
    output logic      pci_rst_n,
    output logic      pin_lvl,
    output logic      wake_wire
);
    logic [2:0] hold_q;

    // ----------------------------------------
    // PCI reset and port-off hold
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_rst_n <= 1'b0;
            hold_q    <= 3'h0;
        end
        else
        begin
            pci_rst_n <= pci_req;
            hold_q    <= (gpio_off_req && !pci_rst_n) ? 3'h7 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
        end
    end

    // Pulled-up lines float high when nobody drives low
    assign pin_lvl   = pin_oe ? pin_out : (flash_on ? flash_bit : !(gpio_off_req || hold_q != 3'h0));
    assign wake_wire = wake_oe ? wake_out : 1'b1;
endmodule : wkld_host_model

`default_nettype wire

// ===== tb/wkld_top_tb.sv
// Self-checking bench of the wake request and port-off block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))

module wkld_top_tb;
    logic clk, rst_n, wake_event, aux, flash_on, flash_bit, pci_req, gpio_off;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    wire logic pci_rst_n, pin_lvl, pin_out, pin_oe, fd0, wk_out, wk_oe, wake_wire;
    wire logic port_disabled, low_power, d3, hreadyout, hresp, irq;
    wire logic [31:0] hrdata;
    int num_errors = 0;
    int compares = 0;

    wkld_top wkld_top_inst (.clk(clk), .rst_n(rst_n), .pci_rst_n(pci_rst_n), .wake_event(wake_event),
        .aux_power_present(aux), .flash_in_use(flash_on), .flash_data_bus_0_in(pin_lvl),
        .flash_data_bus_0_out(pin_out), .flash_data_bus_0_oe(pin_oe), .flash_data_0(fd0),
        .wake_request_n_out(wk_out), .wake_request_n_oe(wk_oe), .port_disabled(port_disabled),
        .low_power(low_power), .d3cold_wake_adv(d3), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    wkld_host_model wkld_host_model_inst (.clk(clk), .rst_n(rst_n), .pci_req(pci_req),
        .gpio_off_req(gpio_off), .flash_on(flash_on), .flash_bit(flash_bit), .pin_out(pin_out),
        .pin_oe(pin_oe), .wake_out(wk_out), .wake_oe(wk_oe), .pci_rst_n(pci_rst_n),
        .pin_lvl(pin_lvl), .wake_wire(wake_wire));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    function automatic logic probe(input int k);
        case (k)
            0: return wk_oe;
            1: return d3;
            2: return port_disabled;
            3: return fd0;
            default: return irq;
        endcase
    endfunction : probe

    task automatic wait_lvl(input int k, input logic v);
        int n;
        n = 0;
        while (probe(k) !== v && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("wait_level", v, probe(k));
        if (probe(k) !== v)
            conclude();
    endtask : wait_lvl

    task automatic edge_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            `CHK("hready_wait", 1, hreadyout);
            conclude();
        end
    endtask : edge_ready

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= a;
        htrans <= wkld_pkg::WKLD_HTRANS_NONSEQ;
        hwrite <= wr;
        edge_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
        `CHK("hresp", 0, hresp);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        `CHK(nm, e, x);
    endtask : rdc

    task automatic pci_down();
        pci_req <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : pci_down

    task automatic pci_up();
        pci_req <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : pci_up

    task automatic wake_pulse();
        wake_event <= 1'b1;
        repeat (8) @(posedge clk);
        wake_event <= 1'b0;
        @(posedge clk);
    endtask : wake_pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset();
        rdc("wakeup_control", wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 0);
        rdc("pm_ctrl", wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 0);
        rdc("block_status", wkld_pkg::WKLD_OFS_BLOCK_STATUS, 0);
        rdc("irq_enable", wkld_pkg::WKLD_OFS_IRQ_ENABLE, 0);
        rdc("irq_clear", wkld_pkg::WKLD_OFS_IRQ_CLEAR, 0);
        rdc("unmapped", 8'h20, 0);
    endtask : sc_reset

    task automatic sc_wake_enable();
        wr(wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h1);
        wake_pulse();
        wait_lvl(0, 1'b1);
        `CHK("wake_wire", 0, wake_wire);
        rdc("irq_status", wkld_pkg::WKLD_OFS_IRQ_STATUS, 32'h3);
        wr(wkld_pkg::WKLD_OFS_IRQ_ENABLE, 32'h2);
        wait_lvl(4, 1'b1);
        wr(wkld_pkg::WKLD_OFS_IRQ_ENABLE, 32'h0);
        wait_lvl(4, 1'b0);
        wr(wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h3);
        wait_lvl(0, 1'b0);
        `CHK("wake_wire", 1, wake_wire);
        wr(wkld_pkg::WKLD_OFS_IRQ_CLEAR, 32'h7);
        rdc("irq_status", wkld_pkg::WKLD_OFS_IRQ_STATUS, 0);
    endtask : sc_wake_enable

    task automatic sc_adv_enable();
        wr(wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h0);
        wake_pulse();
        repeat (8) @(posedge clk);
        `CHK("oe_disabled", 0, wk_oe);
        wr(wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 32'h1);
        wait_lvl(0, 1'b1);
        wr(wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 32'h0);
        wait_lvl(0, 1'b0);
        wr(wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h2);
        wr(wkld_pkg::WKLD_OFS_IRQ_CLEAR, 32'h7);
    endtask : sc_adv_enable

    task automatic sc_aux();
        aux <= 1'b1;
        wait_lvl(1, 1'b1);
        rdc("block_status", wkld_pkg::WKLD_OFS_BLOCK_STATUS, 32'h3);
        rdc("irq_aux_change", wkld_pkg::WKLD_OFS_IRQ_STATUS, 32'h4);
        wr(wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h1);
        wr(wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 32'h1);
        wake_pulse();
        wait_lvl(0, 1'b1);
        pci_down();
        wr(wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 32'h0);
        rdc("write_in_reset", wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 32'h1);
        `CHK("oe_in_reset", 1, wk_oe);
        pci_up();
        rdc("adv_cleared", wkld_pkg::WKLD_OFS_WAKEUP_CONTROL, 0);
        rdc("pm_kept", wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 32'h3);
        `CHK("oe_kept", 1, wk_oe);
        aux <= 1'b0;
        wait_lvl(1, 1'b0);
        pci_down();
        pci_up();
        wait_lvl(0, 1'b0);
        rdc("pm_cleared", wkld_pkg::WKLD_OFS_PM_CTRL_STATUS, 0);
        wr(wkld_pkg::WKLD_OFS_IRQ_CLEAR, 32'h7);
    endtask : sc_aux

    task automatic sc_port_off();
        gpio_off <= 1'b1;
        pci_down();
        gpio_off <= 1'b0;
        pci_up();
        wait_lvl(2, 1'b1);
        `CHK("low_power", 1, low_power);
        `CHK("shared_pin_oe", 0, pin_oe);
        rdc("block_status", wkld_pkg::WKLD_OFS_BLOCK_STATUS, 32'hc);
        flash_on <= 1'b1;
        pci_down();
        pci_up();
        wait_lvl(2, 1'b0);
        wait_lvl(3, 1'b0);
        flash_bit <= 1'b1;
        wait_lvl(3, 1'b1);
    endtask : sc_port_off

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        `CHK("watchdog", 0, 1);
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        wake_event = 1'b0;
        aux = 1'b0;
        flash_on = 1'b0;
        flash_bit = 1'b0;
        pci_req = 1'b0;
        gpio_off = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        pci_up();
        sc_reset();
        sc_wake_enable();
        sc_adv_enable();
        sc_aux();
        sc_port_off();
        conclude();
    end
endmodule : wkld_top_tb

`default_nettype wire
